// ---- core/pan_pkg.sv ----
// Package: register map, field layout and carriers for the autoneg registers
package pan_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL    = 4'h0;
    localparam logic [3:0] IDX_ADVERT  = 4'h4;
    localparam logic [3:0] IDX_PARTNER = 4'h5;
    localparam logic [3:0] IDX_EXPAND  = 4'h6;
    localparam logic [3:0] IDX_IRQ_ST  = 4'h8;
    localparam logic [3:0] IDX_IRQ_CLR = 4'h9;
    localparam logic [3:0] IDX_IRQ_EN  = 4'hA;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_RESTART_BIT = 9;
    localparam int NEXT_PAGE_BIT    = 15;
    localparam int ACK_BIT          = 14;
    localparam int REM_FAULT_BIT    = 13;
    localparam int PAUSE_HI_BIT     = 11;
    localparam int PAUSE_LO_BIT     = 10;
    localparam int T4_BIT           = 9;
    localparam int EXP_PD_FAULT_BIT = 4;
    localparam int EXP_LP_NP_BIT    = 3;
    localparam int EXP_NP_BIT       = 2;
    localparam int EXP_PAGE_RX_BIT  = 1;
    localparam int EXP_LP_AN_BIT    = 0;

    // ------------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] ADVERT_WR_MASK  = 16'h2DFF;
    localparam logic [15:0] ADVERT_RESET    = 16'h01E1;
    localparam logic [15:0] PARTNER_CAP_MSK = 16'h2FFF;
    localparam logic [15:0] PARTNER_RESET   = 16'h0001;
    localparam logic [15:0] EXPAND_RESET    = 16'h0000;
    localparam logic [2:0]  IRQ_RESET       = 3'h0;

    // Interrupt status bit positions
    localparam int IRQ_PAGE_BIT  = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_DONE_BIT  = 2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Code word arriving from the link partner
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } pan_page_t;

    // Resolved pause outcome
    typedef struct packed {
        logic sym;
        logic asym;
    } pan_pause_t;

endpackage : pan_pkg

// ---- core/pan_regs.sv ----
// Module: autoneg advertisement, partner ability and expansion registers
//
// Design decision made here: the Wishbone interface to the registers.

// Contract
// - Advert pause field 11:10, RW, reset 00
// - Both pauses advertised resolve to one
// - Advert ability bits 8:5 RW, reset one
// - Selector 00001 at 4:0 both registers at reset; advert selector RW, partner selector captured from code word
// - Advert remote fault bit 13, RW
// - Partner next page bit reads zero
// - Partner bit 14 set on code word
// - Partner pause captured into 11:10
// - Partner T4 bit 9, RO, reset zero
// - Partner fault and abilities captured, RO
// - Expansion bit 4 latches parallel fault
// - Expansion bit 3 partner next page
// - Expansion bit 2 reads zero
// - Expansion bit 1 latches page received
// - Expansion bit 0 partner autoneg able
// - Control bit 9 restarts, self clears
module pan_regs (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [5:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    // Link side
    input  wire pan_pkg::pan_page_t page_i,
    input  wire logic               pd_fault_i,
    input  wire logic               an_done_i,
    output logic      [15:0]        advert_o,
    output logic                    restart_o,
    output pan_pkg::pan_pause_t     pause_o,
    // Interrupt
    output logic                    irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [15:0] advert_reg;
    logic [15:0] partner_reg;
    logic [15:0] expand_reg;
    logic [2:0]  irq_st_reg;
    logic [2:0]  irq_en_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        restart_reg;
    logic        done_d_reg;
    pan_pkg::pan_pause_t pause_reg;
    logic        req;
    logic        wr;
    logic        rd;
    logic [3:0]  idx;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic        rd_expand;
    logic        done_rise;
    logic [2:0]  irq_set;
    logic [31:0] rd_next;
    pan_pkg::pan_pause_t pause_next;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Request is taken on the edge where ack is low
    assign req   = cyc_i & stb_i & ~ack_reg;
    assign wr    = req & we_i;
    assign rd    = req & ~we_i;
    assign idx   = adr_i[5:2];
    assign wdata = dat_i[15:0];
    assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    assign rd_expand = rd & (idx == pan_pkg::IDX_EXPAND);

    // Ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // Read data mux, unmapped and write-only read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (idx)
            pan_pkg::IDX_ADVERT:  rd_next[15:0] = advert_reg;
            pan_pkg::IDX_PARTNER: rd_next[15:0] = partner_reg;
            pan_pkg::IDX_EXPAND:  rd_next[15:0] = expand_reg;
            pan_pkg::IDX_IRQ_ST:  rd_next[2:0]  = irq_st_reg;
            pan_pkg::IDX_IRQ_EN:  rd_next[2:0]  = irq_en_reg;
            default:              rd_next       = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (rd) begin
            dat_reg <= rd_next;
        end
    end

    // ------------------------------------------------------------------
    // Advertisement register
    // ------------------------------------------------------------------
    // Only pause, fault, ability and selector bits are writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            advert_reg <= pan_pkg::ADVERT_RESET;
        end else if (wr && idx == pan_pkg::IDX_ADVERT) begin
            advert_reg <= (advert_reg & ~(wmask & pan_pkg::ADVERT_WR_MASK))
                        | (wdata & wmask & pan_pkg::ADVERT_WR_MASK);
        end
    end

    // ------------------------------------------------------------------
    // Restart control
    // ------------------------------------------------------------------
    // Self-clearing restart pulse, control reads back zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= wr && idx == pan_pkg::IDX_CTRL && sel_i[1]
                        && dat_i[pan_pkg::CTRL_RESTART_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Partner ability register
    // ------------------------------------------------------------------
    // Capture code word, set acknowledge, next page forced low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            partner_reg <= pan_pkg::PARTNER_RESET;
        end else if (restart_reg) begin
            partner_reg <= pan_pkg::PARTNER_RESET;
        end else if (page_i.valid) begin
            partner_reg <= page_i.word & pan_pkg::PARTNER_CAP_MSK;
            partner_reg[pan_pkg::ACK_BIT]       <= 1'b1;
            partner_reg[pan_pkg::NEXT_PAGE_BIT] <= 1'b0;
            partner_reg[12]                     <= 1'b0;
            partner_reg[pan_pkg::T4_BIT]        <= page_i.word[9];
        end
    end

    // ------------------------------------------------------------------
    // Expansion register
    // ------------------------------------------------------------------
    // Latched bits clear on read; a new event in the read cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expand_reg <= pan_pkg::EXPAND_RESET;
        end else if (restart_reg) begin
            expand_reg <= pan_pkg::EXPAND_RESET;
        end else begin
            expand_reg[pan_pkg::EXP_PD_FAULT_BIT] <= pd_fault_i
                | (expand_reg[pan_pkg::EXP_PD_FAULT_BIT]
                   & ~rd_expand);
            expand_reg[pan_pkg::EXP_PAGE_RX_BIT]  <= page_i.valid
                | (expand_reg[pan_pkg::EXP_PAGE_RX_BIT]
                   & ~rd_expand);
            expand_reg[pan_pkg::EXP_NP_BIT]       <= 1'b0;
            if (page_i.valid) begin
                expand_reg[pan_pkg::EXP_LP_NP_BIT] <=
                    page_i.word[pan_pkg::NEXT_PAGE_BIT];
                expand_reg[pan_pkg::EXP_LP_AN_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pause resolution
    // ------------------------------------------------------------------
    // At most one of symmetric or asymmetric is chosen
    always_comb begin
        pause_next = '0;
        if (advert_reg[pan_pkg::PAUSE_LO_BIT]
            && partner_reg[pan_pkg::PAUSE_LO_BIT]) begin
            pause_next.sym = 1'b1;
        end else if (advert_reg[pan_pkg::PAUSE_HI_BIT]
                     && partner_reg[pan_pkg::PAUSE_HI_BIT]
                     && (advert_reg[pan_pkg::PAUSE_LO_BIT]
                         ^ partner_reg[pan_pkg::PAUSE_LO_BIT])) begin
            pause_next.asym = 1'b1;
        end
    end

    // Resolved pause held only while negotiation is complete
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pause_reg <= '0;
        end else if (an_done_i && !restart_reg) begin
            pause_reg <= pause_next;
        end else begin
            pause_reg <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Completion edge detect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_d_reg <= 1'b0;
        end else begin
            done_d_reg <= an_done_i;
        end
    end

    assign done_rise = an_done_i & ~done_d_reg;
    assign irq_set   = {done_rise, pd_fault_i, page_i.valid};

    // Sticky status, write-one-to-clear, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_reg <= pan_pkg::IRQ_RESET;
        end else if (wr && idx == pan_pkg::IDX_IRQ_CLR && sel_i[0]) begin
            irq_st_reg <= irq_set | (irq_st_reg & ~dat_i[2:0]);
        end else begin
            irq_st_reg <= irq_set | irq_st_reg;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_reg <= pan_pkg::IRQ_RESET;
        end else if (wr && idx == pan_pkg::IDX_IRQ_EN && sel_i[0]) begin
            irq_en_reg <= dat_i[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ack_o     = ack_reg;
    assign dat_o     = dat_reg;
    assign advert_o  = advert_reg;
    assign restart_o = restart_reg;
    assign pause_o   = pause_reg;
    assign irq_o     = |(irq_st_reg & irq_en_reg);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pause_one_hot: assert property (!(pause_o.sym && pause_o.asym))
        else $error("both pause modes resolved");
    a_partner_np_zero: assert property (!partner_reg[15])
        else $error("partner next page bit set");
    a_ack_on_page: assert property (page_i.valid && !restart_reg
        |=> partner_reg[14])
        else $error("acknowledge bit not set after code word");
    a_pause_capture: assert property (page_i.valid && !restart_reg
        |=> partner_reg[11:10] == $past(page_i.word[11:10]))
        else $error("partner pause not captured");
    a_fault_latch: assert property (pd_fault_i && !restart_reg
        |=> expand_reg[4])
        else $error("parallel fault not latched");
    a_fault_hold: assert property (expand_reg[4] && !rd_expand
        && !restart_reg |=> expand_reg[4])
        else $error("fault flag lost before read");
    a_local_np_zero: assert property (expand_reg[2] == 1'b0)
        else $error("local next page bit set");
    a_page_clear: assert property (rd_expand && !page_i.valid
        && !restart_reg ##1 1'b1 |=> !expand_reg[1] || page_i.valid
        || $past(page_i.valid))
        else $error("page received not cleared by read");
    a_restart_pulse: assert property (restart_o |=> !restart_o)
        else $error("restart not self clearing");
    a_restart_clear: assert property (restart_o |=> partner_reg
        == pan_pkg::PARTNER_RESET)
        else $error("partner word not cleared by restart");
    a_reserved_zero: assert property (advert_reg[15:14] == 2'b00
        && !advert_reg[12] && !advert_reg[9])
        else $error("reserved advert bits set");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    // ------------------------------------------------------------------
    // Advertisement checks
    // ------------------------------------------------------------------
    // Full-word write lands through the writable mask only
    a_advert_write: assert property (wr && idx == pan_pkg::IDX_ADVERT
        && sel_i == 4'h3 |=> advert_reg
        == (($past(wdata) & pan_pkg::ADVERT_WR_MASK)
        | ($past(advert_reg) & ~pan_pkg::ADVERT_WR_MASK)))
        else $error("advert write not applied through mask");
    // Selector and fault bits hold without a write
    a_advert_stable: assert property (!(wr && idx == pan_pkg::IDX_ADVERT)
        |=> $stable(advert_reg))
        else $error("advert changed without a write");

    // ------------------------------------------------------------------
    // Partner ability checks
    // ------------------------------------------------------------------
    // Reserved partner bit stays low whatever the partner sends
    a_partner_rsvd: assert property (!partner_reg[12])
        else $error("reserved partner bit set");
    // T4 ability taken from the code word
    a_partner_t4: assert property (page_i.valid && !restart_reg
        |=> partner_reg[9] == $past(page_i.word[9]))
        else $error("partner T4 bit not captured");
    // Fault and ability bits taken from the code word
    a_partner_cap: assert property (page_i.valid && !restart_reg
        |=> partner_reg[13] == $past(page_i.word[13])
        && partner_reg[8:5] == $past(page_i.word[8:5]))
        else $error("partner abilities not captured");
    // Read-only word holds between pages
    a_partner_hold: assert property (!page_i.valid && !restart_reg
        |=> $stable(partner_reg))
        else $error("partner word changed without a page");

    // ------------------------------------------------------------------
    // Expansion checks
    // ------------------------------------------------------------------
    // Reserved expansion bits stay low
    a_expand_rsvd: assert property (expand_reg[15:5] == 11'h000)
        else $error("reserved expansion bits set");
    // Partner next page ability follows the code word
    a_lp_np_copy: assert property (page_i.valid && !restart_reg
        |=> expand_reg[3] == $past(page_i.word[15]))
        else $error("partner next page ability not captured");
    // Any received page marks the partner as autoneg able
    a_lp_an_set: assert property (page_i.valid && !restart_reg
        |=> expand_reg[0])
        else $error("partner autoneg able not set");
    // Page received latches on a new page
    a_page_latch: assert property (page_i.valid && !restart_reg
        |=> expand_reg[1])
        else $error("page received not latched");
    // Read with the fault gone clears the fault flag
    a_fault_clear: assert property (rd_expand && !pd_fault_i
        && !restart_reg |=> !expand_reg[4])
        else $error("fault flag not cleared by read");

    // ------------------------------------------------------------------
    // Restart, pause, bus and interrupt checks
    // ------------------------------------------------------------------
    // Control write with bit 9 raises the restart pulse
    a_restart_cause: assert property (wr && idx == pan_pkg::IDX_CTRL
        && sel_i[1] && dat_i[pan_pkg::CTRL_RESTART_BIT]
        |=> restart_o)
        else $error("restart not raised by control write");
    // Restart refreshes the expansion word
    a_restart_expand: assert property (restart_o |=> expand_reg
        == pan_pkg::EXPAND_RESET)
        else $error("expansion not cleared by restart");
    // No resolved pause outside completed negotiation
    a_pause_idle: assert property (!an_done_i |=> pause_o == '0)
        else $error("pause resolved without completion");
    // Every taken request is answered next cycle
    a_ack_follows: assert property (req |=> ack_o)
        else $error("request not acknowledged");
    // Page status stays set until cleared by software
    a_irq_sticky: assert property (irq_st_reg[0]
        && !(wr && idx == pan_pkg::IDX_IRQ_CLR) |=> irq_st_reg[0])
        else $error("page status lost before clear");

    c_page_rx: cover property (page_i.valid ##1 rd_expand);
    c_fault: cover property (pd_fault_i ##1 rd_expand);
    c_restart: cover property (restart_o ##[1:20] page_i.valid);
    c_pause_sym: cover property (pause_o.sym);
    c_irq: cover property (irq_o);

endmodule : pan_regs

// ---- sim/pan_link_partner.sv ----
// Link partner model: delivers code words as one-cycle pulses
module pan_link_partner (
    // Clock
    input  wire logic          clk_i,
    // Code word toward the device
    output pan_pkg::pan_page_t page_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Idle line
    // ------------------------------------------------------------------
    initial begin
        page_o.valid = 1'b0;
        page_o.word  = 16'h0000;
    end

    // ------------------------------------------------------------------
    // Word delivery
    // ------------------------------------------------------------------
    // Waits gap idle cycles, so answers come both promptly and slowly
    task automatic send(input logic [15:0] w, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        page_o.valid <= 1'b1;
        page_o.word  <= w;
        @(posedge clk_i);
        page_o.valid <= 1'b0;
        page_o.word  <= ~w;  // Released line shows no stale word
    endtask : send
endmodule : pan_link_partner

// ---- sim/pan_regs_test.sv ----
// Testbench: autoneg register bank against a behavioural model
module pan_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk_i, rst_i, cyc, stb, we, pd_fault, an_done;
    logic               ack, restart, irq, seen;
    logic [5:0]         adr;
    logic [31:0]        wdat, rdat, seed, t;
    logic [15:0]        rd, w, e;
    logic [15:0]        pages[$];
    pan_pkg::pan_page_t page;
    pan_pkg::pan_pause_t pause;
    int                 failures, compares, n, sym, asym;

    pan_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .page_i(page), .pd_fault_i(pd_fault),
        .an_done_i(an_done), .advert_o(w), .restart_o(restart),
        .pause_o(pause), .irq_o(irq));
    pan_link_partner lp (.clk_i(clk_i), .page_o(page));

    // Clock at 40 MHz
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Partner word as seen in the partner register
    function automatic logic [15:0] pmodel(input logic [15:0] x);
        return (x & 16'h2FFF) | 16'h4000;
    endfunction : pmodel

    task automatic chk(input string nm, input logic [15:0] ex, gt);
        compares++;
        if (gt !== ex) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, ex, gt);
        end
    endtask : chk

    // Classic Wishbone single cycle, held until ack is sampled
    task automatic wb(input logic wr, input logic [3:0] idx,
                      input logic [15:0] d, output logic [15:0] r);
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= wr;
        adr  <= {idx, 2'b00};
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 16'h0001, 16'h0000);
        r = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rdc(input logic [3:0] idx, input logic [15:0] ex,
                       input string nm);
        logic [15:0] r;
        wb(1'b0, idx, 16'h0000, r);
        chk(nm, ex, r);
    endtask : rdc

    task automatic conclude();
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        conclude();
    end

    // Main sequence
    initial begin
        {cyc, stb, we, pd_fault, an_done, adr, wdat} = '0;
        failures = 0;
        compares = 0;
        seed = 32'h85f5_6a0d;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(pan_pkg::IDX_ADVERT, 16'h01E1, "advert");
        rdc(pan_pkg::IDX_PARTNER, 16'h0001, "partner");
        rdc(pan_pkg::IDX_EXPAND, 16'h0000, "expand");
        $display("Test reset values done");
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            e = (i == 0) ? 16'h2DFF : t[15:0] & 16'h2DFF;
            wb(1'b1, pan_pkg::IDX_ADVERT, (i == 0) ? 16'hFFFF : t[15:0], rd);
            rdc(pan_pkg::IDX_ADVERT, e, "advert rw");
            chk("advert_o", e, w);
        end
        wb(1'b1, pan_pkg::IDX_PARTNER, 16'hFFFF, rd);
        rdc(pan_pkg::IDX_PARTNER, 16'h0001, "partner ro");
        $display("Test advertisement done");
        for (int i = 0; i < 6; i++) begin
            t = rnd();
            pages.push_back(t[15:0]);
            lp.send(t[15:0], i % 3);
            rdc(pan_pkg::IDX_PARTNER, pmodel(pages[$]), "partner");
            e = {12'h000, pages[$][15], 3'b011};
            rdc(pan_pkg::IDX_EXPAND, e, "expand page");
            rdc(pan_pkg::IDX_EXPAND, e & 16'hFFFD, "expand read");
        end
        pd_fault <= 1'b1;
        @(posedge clk_i);
        pd_fault <= 1'b0;
        rdc(pan_pkg::IDX_EXPAND, (e & 16'hFFFD) | 16'h0010, "pd fault");
        rdc(pan_pkg::IDX_EXPAND, e & 16'hFFFD, "pd clear");
        pd_fault <= 1'b1;
        rdc(pan_pkg::IDX_EXPAND, (e & 16'hFFFD) | 16'h0010, "pd held");
        rdc(pan_pkg::IDX_EXPAND, (e & 16'hFFFD) | 16'h0010, "pd held");
        pd_fault <= 1'b0;
        $display("Test partner and expansion done");
        wb(1'b1, pan_pkg::IDX_IRQ_CLR, 16'h0007, rd);
        wb(1'b1, pan_pkg::IDX_IRQ_EN, 16'h0001, rd);
        chk("irq idle", 16'h0000, {15'h0000, irq});
        lp.send(16'h0001, 1);
        repeat (2) @(posedge clk_i);
        chk("irq page", 16'h0001, {15'h0000, irq});
        rdc(pan_pkg::IDX_IRQ_ST, 16'h0001, "irq status");
        wb(1'b1, pan_pkg::IDX_IRQ_EN, 16'h0002, rd);
        rdc(pan_pkg::IDX_IRQ_EN, 16'h0002, "irq enable");
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wb(1'b1, pan_pkg::IDX_IRQ_CLR, 16'h0001, rd);
        rdc(pan_pkg::IDX_IRQ_ST, 16'h0000, "irq cleared");
        rdc(4'hF, 16'h0000, "unmapped");
        $display("Test interrupts done");
        for (int a = 0; a < 4; a++) begin
            for (int p = 0; p < 4; p++) begin
                wb(1'b1, pan_pkg::IDX_ADVERT, 16'h01E1 | (16'(a) << 10), rd);
                lp.send(16'h0001 | (16'(p) << 10), p % 2);
                an_done <= 1'b1;
                repeat (3) @(posedge clk_i);
                sym = a[0] & p[0];
                asym = !sym && a[1] && p[1] && (a[0] != p[0]);
                chk("pause", 16'(sym * 2 + asym), {14'h0000, pause});
                an_done <= 1'b0;
                repeat (3) @(posedge clk_i);
                chk("pause idle", 16'h0000, {14'h0000, pause});
            end
        end
        rdc(pan_pkg::IDX_IRQ_ST, 16'h0005, "irq done");
        $display("Test pause resolution done");
        wb(1'b1, pan_pkg::IDX_CTRL, 16'h0200, rd);
        seen = (restart === 1'b1);
        repeat (5) begin
            @(posedge clk_i);
            if (restart === 1'b1) seen = 1'b1;
        end
        chk("restart", 16'h0001, {15'h0000, seen});
        chk("restart low", 16'h0000, {15'h0000, restart});
        rdc(pan_pkg::IDX_PARTNER, 16'h0001, "partner restart");
        rdc(pan_pkg::IDX_EXPAND, 16'h0000, "expand restart");
        rdc(pan_pkg::IDX_CTRL, 16'h0000, "control");
        $display("Test restart done");
        conclude();
    end
endmodule : pan_regs_test
